/* File: verilog/dram_pre_ctrl.sv */
// Purpose: controller end that spaces commands per bank timing
// Assumes: user holds a request until o_req_taken pulses
// Notes:   Function
`timescale 1ns/1ps
module dram_pre_ctrl
   import dram_pre_pkg::*;
(
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst,
   input  wire logic             i_ce,
   input  wire logic             i_bl32,
   input  wire logic             i_req_valid,
   input  wire cmd_t             i_req_cmd,
   input  wire logic [BA_W-1:0]  i_req_bank,
   input  wire logic             i_req_flag,
   dram_cmd_if.ctl               link,
   output logic                  o_req_taken,
   output logic      [NBANK-1:0] o_bank_open
);
   cmd_t             cmd_reg;
   logic [BA_W-1:0]  bank_reg;
   logic             ca5_reg;
   logic             req_act;
   logic             req_rd;
   logic             req_rw;
   logic             req_pre;
   logic             auto_precharge_flag;
   logic             all_bank_flag;
   logic             legal;
   logic             issue;
   logic [TW-1:0]    rd_pre;
   logic [TW-1:0]    ap_rd;
   logic [TW-1:0]    wr_pre;
   logic [TW-1:0]    acc_pre;
   logic [TW-1:0]    ap_act;
   logic [TW-1:0]    act_val;
   logic [NBANK-1:0] hit;
   logic [NBANK-1:0] act_done;
   logic [NBANK-1:0] pre_done;
   logic [NBANK-1:0] rw_done;
   logic [NBANK-1:0] wr_clear;
   logic [NBANK-1:0] act_ld;
   logic [NBANK-1:0] pre_ld;
   logic [NBANK-1:0] rcd_ld;
   logic [NBANK-1:0] open_next;
   logic [NBANK-1:0] ok;

   assign req_act = i_req_cmd == CMD_ACT;
   assign req_rd  = i_req_cmd == CMD_RD;
   assign req_rw  = i_req_cmd inside {CMD_RD, CMD_WR, CMD_MWR};
   assign req_pre = i_req_cmd == CMD_PRE;
   assign auto_precharge_flag = i_req_flag;
   assign all_bank_flag       = i_req_flag;

   // read spacing: max of BL/2 and (BL/2 - 8) + nRTP
   assign rd_pre = i_bl32 ? RD_PRE32 : RD_PRE16;
   assign ap_rd  = i_bl32 ? AP_RD32 : AP_RD16;
   assign wr_pre = i_bl32 ? WR_PRE32 : WR_PRE16;
   // a read with auto-precharge only holds off precharge until its own start
   assign acc_pre = req_rd ? (auto_precharge_flag ? ap_rd : rd_pre)
                           : wr_pre;
   // auto-precharge start plus per-bank row precharge
   assign ap_act = (req_rd ? ap_rd : wr_pre) + N_RPPB;
   assign act_val = req_act ? N_RC
                  : req_pre ? (all_bank_flag ? N_RPAB : N_RPPB)
                  : ap_act;

   for (genvar b = 0; b < NBANK; b++) begin : g_bank
      logic [TW-1:0] pre_cnt;
      logic          sel;

      assign hit[b] = i_req_bank == BA_W'(b);
      assign sel    = issue && hit[b];

      // per-bank hold-off counters
      bank_timer u_act (
         .i_ref_clk (i_ref_clk),
         .i_rst     (i_rst),
         .i_ce      (i_ce),
         .i_load    (act_ld[b]),
         .i_value   (act_val),
         .o_count   (),
         .o_done    (act_done[b])
      );
      bank_timer u_pre (
         .i_ref_clk (i_ref_clk),
         .i_rst     (i_rst),
         .i_ce      (i_ce),
         .i_load    (pre_ld[b]),
         .i_value   (req_act ? N_RAS : acc_pre),
         .o_count   (pre_cnt),
         .o_done    (pre_done[b])
      );
      bank_timer u_rcd (
         .i_ref_clk (i_ref_clk),
         .i_rst     (i_rst),
         .i_ce      (i_ce),
         .i_load    (rcd_ld[b]),
         .i_value   (N_RCD),
         .o_count   (),
         .o_done    (rw_done[b])
      );

      assign act_ld[b] = (sel && (req_act
                                  || (req_rw && auto_precharge_flag)))
                       || (issue && req_pre
                           && (all_bank_flag || hit[b]));
      assign pre_ld[b] = sel && (req_act || req_rw);
      assign rcd_ld[b] = sel && req_act;
      // recovery left must end before the internal precharge
      assign wr_clear[b] = pre_cnt <= ap_rd + ONE_CNT;

      assign open_next[b] =
           (sel && req_act) ? 1'b1
         : (sel && req_rw && auto_precharge_flag) ? 1'b0
         : (issue && req_pre && (all_bank_flag || hit[b])) ? 1'b0
         : o_bank_open[b];

      // per-bank admission of the request
      assign ok[b] =
           req_act ? (!o_bank_open[b] && act_done[b])
         : req_rw  ? (o_bank_open[b] && rw_done[b]
                      && (!(req_rd && auto_precharge_flag)
                          || wr_clear[b]))
         : req_pre ? (all_bank_flag ? (&pre_done)
                                    : pre_done[b])
         : 1'b0;
   end

   assign legal = |(ok & hit);
   assign issue = i_req_valid && legal && !o_req_taken;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         cmd_reg     <= CMD_NOP;
         bank_reg    <= '0;
         ca5_reg     <= 1'b0;
         o_req_taken <= 1'b0;
         o_bank_open <= '0;
      end else if (i_ce) begin
         cmd_reg     <= issue ? i_req_cmd : CMD_NOP;
         bank_reg    <= issue ? i_req_bank : '0;
         ca5_reg     <= issue && i_req_flag;
         o_req_taken <= issue;
         o_bank_open <= open_next;
      end
   end

   assign link.cmd  = cmd_reg;
   assign link.bank = bank_reg;
   assign link.ca5  = ca5_reg;
endmodule : dram_pre_ctrl

/* File: verilog/dram_pre_pkg.sv */
// Purpose: shared constants and command codes for precharge timing
// Assumes: 50 MHz command clock, times held in picoseconds
// Notes:   cycle counts round analog minimums up to whole clocks
package dram_pre_pkg;
   localparam int CLK_MHZ   = 50;
   localparam int T_CK_PS   = 1000000 / CLK_MHZ;
   localparam int T_RAS_PS  = 42000;
   localparam int T_RCD_PS  = 18000;
   localparam int T_RPPB_PS = 18000;
   localparam int T_RPAB_PS = 21000;
   localparam int T_RTP_PS  = 7500;
   localparam int T_WR_PS   = 18000;
   localparam int T_RC_PS   = T_RAS_PS + T_RPAB_PS;
   localparam int WL_CYC    = 6;
   localparam int HALF_BL16 = 8;
   localparam int HALF_BL32 = 16;
   localparam int RTP_OFS   = 8;
   localparam int WR_EXTRA  = 1;
   localparam int NBANK     = 8;
   localparam int BA_W      = 3;
   localparam int TW        = 8;

   localparam int C_RAS  = (T_RAS_PS + T_CK_PS - 1) / T_CK_PS;
   localparam int C_RCD  = (T_RCD_PS + T_CK_PS - 1) / T_CK_PS;
   localparam int C_RPPB = (T_RPPB_PS + T_CK_PS - 1) / T_CK_PS;
   localparam int C_RPAB = (T_RPAB_PS + T_CK_PS - 1) / T_CK_PS;
   localparam int C_RTP  = (T_RTP_PS + T_CK_PS - 1) / T_CK_PS;
   localparam int C_WR   = (T_WR_PS + T_CK_PS - 1) / T_CK_PS;
   localparam int C_RC   = (T_RC_PS + T_CK_PS - 1) / T_CK_PS;
   localparam int C_AP16 = HALF_BL16 - RTP_OFS + C_RTP;
   localparam int C_AP32 = HALF_BL32 - RTP_OFS + C_RTP;
   localparam int C_WP16 = WL_CYC + HALF_BL16 + WR_EXTRA + C_WR;
   localparam int C_WP32 = WL_CYC + HALF_BL32 + WR_EXTRA + C_WR;
   localparam int C_RP16 = C_AP16 > HALF_BL16 ? C_AP16 : HALF_BL16;
   localparam int C_RP32 = C_AP32 > HALF_BL32 ? C_AP32 : HALF_BL32;

   localparam logic [TW-1:0] N_RAS  = TW'(C_RAS);
   localparam logic [TW-1:0] N_RCD  = TW'(C_RCD);
   localparam logic [TW-1:0] N_RPPB = TW'(C_RPPB);
   localparam logic [TW-1:0] N_RPAB = TW'(C_RPAB);
   localparam logic [TW-1:0] N_RC   = TW'(C_RC);
   localparam logic [TW-1:0] AP_RD16 = TW'(C_AP16);
   localparam logic [TW-1:0] AP_RD32 = TW'(C_AP32);
   localparam logic [TW-1:0] WR_PRE16 = TW'(C_WP16);
   localparam logic [TW-1:0] WR_PRE32 = TW'(C_WP32);
   localparam logic [TW-1:0] RD_PRE16 = TW'(C_RP16);
   localparam logic [TW-1:0] RD_PRE32 = TW'(C_RP32);
   localparam logic [TW-1:0] ONE_CNT  = TW'(1);

   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_MWR, CMD_PRE
   } cmd_t;
endpackage : dram_pre_pkg

/* File: verilog/dram_cmd_if.sv */
// Purpose: command/address link between controller and memory
// Assumes: both ends on i_ref_clk
// Notes:   ca5 is the auto-precharge or all-bank flag by command
`timescale 1ns/1ps
interface dram_cmd_if;
   import dram_pre_pkg::*;
   cmd_t            cmd;
   logic [BA_W-1:0] bank;
   logic            ca5;
   modport dev (input cmd, input bank, input ca5);
   modport ctl (output cmd, output bank, output ca5);
endinterface : dram_cmd_if

/* File: verilog/bank_timer.sv */
// Purpose: hold-off down counter, keeps the longest pending wait
// Assumes: load of n means done n cycles after the load cycle
// Notes:   a shorter load never cuts a longer running wait
`timescale 1ns/1ps
module bank_timer
   import dram_pre_pkg::*;
(
   input  wire logic          i_ref_clk,
   input  wire logic          i_rst,
   input  wire logic          i_ce,
   input  wire logic          i_load,
   input  wire logic [TW-1:0] i_value,
   output logic      [TW-1:0] o_count,
   output logic               o_done
);
   logic [TW-1:0] count_reg;
   logic [TW-1:0] count_dec;
   logic [TW-1:0] count_next;

   assign count_dec  = (count_reg == '0) ? '0 : count_reg - ONE_CNT;
   assign count_next = (i_load && i_value > count_dec) ? i_value
                                                       : count_dec;
   assign o_count = count_reg;
   assign o_done  = count_reg <= ONE_CNT;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst)
         count_reg <= '0;
      else if (i_ce)
         count_reg <= count_next;
   end
endmodule : bank_timer

/* File: verilog/dram_pre_device.sv */
// Purpose: memory-side bank state with auto-precharge scheduling
// Assumes: commands arrive on the link in the cycle they apply
// Notes:   o_illegal flags commands that break bank state or tRP
`timescale 1ns/1ps
module dram_pre_device
   import dram_pre_pkg::*;
(
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst,
   input  wire logic             i_ce,
   input  wire logic             i_bl32,
   dram_cmd_if.dev               link,
   output logic      [NBANK-1:0] o_bank_open,
   output logic      [NBANK-1:0] o_ap_start,
   output logic                  o_illegal
);
   logic             is_act;
   logic             is_rd;
   logic             is_rw;
   logic             is_pre;
   logic             auto_precharge_flag;
   logic             all_bank_flag;
   logic [TW-1:0]    ap_dly;
   logic [NBANK-1:0] open_next;
   logic [NBANK-1:0] pend_reg;
   logic [NBANK-1:0] pend_next;
   logic [NBANK-1:0] go;
   logic [NBANK-1:0] ras_done;
   logic [NBANK-1:0] ap_done;
   logic [NBANK-1:0] rp_done;
   logic [NBANK-1:0] bad;

   assign is_act = link.cmd == CMD_ACT;
   assign is_rd  = link.cmd == CMD_RD;
   assign is_rw  = link.cmd inside {CMD_RD, CMD_WR, CMD_MWR};
   assign is_pre = link.cmd == CMD_PRE;
   assign auto_precharge_flag = link.ca5;
   assign all_bank_flag       = link.ca5;
   // burst of BL/2 clocks ends on a 16-beat prefetch boundary
   assign ap_dly = is_rd ? (i_bl32 ? AP_RD32 : AP_RD16)
                         : (i_bl32 ? WR_PRE32 : WR_PRE16);

   for (genvar b = 0; b < NBANK; b++) begin : g_bank
      logic          hit;
      logic          act_b;
      logic          rw_b;
      logic          ap_b;
      logic          pre_b;
      logic [TW-1:0] rp_val;

      assign hit    = link.bank == BA_W'(b);
      assign act_b  = is_act && hit;
      assign rw_b   = is_rw && hit;
      assign ap_b   = rw_b && auto_precharge_flag;
      assign pre_b  = is_pre && (all_bank_flag || hit);
      assign rp_val = (pre_b && all_bank_flag) ? N_RPAB : N_RPPB;

      bank_timer u_ras (
         .i_ref_clk (i_ref_clk),
         .i_rst     (i_rst),
         .i_ce      (i_ce),
         .i_load    (act_b),
         .i_value   (N_RAS),
         .o_count   (),
         .o_done    (ras_done[b])
      );
      bank_timer u_ap (
         .i_ref_clk (i_ref_clk),
         .i_rst     (i_rst),
         .i_ce      (i_ce),
         .i_load    (ap_b),
         .i_value   (ap_dly),
         .o_count   (),
         .o_done    (ap_done[b])
      );
      bank_timer u_rp (
         .i_ref_clk (i_ref_clk),
         .i_rst     (i_rst),
         .i_ce      (i_ce),
         .i_load    (pre_b || go[b]),
         .i_value   (rp_val),
         .o_count   (),
         .o_done    (rp_done[b])
      );

      // precharge waits for tRAS as well as the access delay
      assign go[b] = pend_reg[b] && ap_done[b] && ras_done[b];
      assign open_next[b] = act_b ? 1'b1
                          : (pre_b || go[b]) ? 1'b0
                          : o_bank_open[b];
      assign pend_next[b] = ap_b ? 1'b1
                          : (pre_b || go[b]) ? 1'b0
                          : pend_reg[b];
      assign bad[b] = (act_b && (o_bank_open[b] || !rp_done[b]))
                    || (rw_b && (!o_bank_open[b] || pend_reg[b]));
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_bank_open <= '0;
         pend_reg    <= '0;
         o_ap_start  <= '0;
         o_illegal   <= 1'b0;
      end else if (i_ce) begin
         o_bank_open <= open_next;
         pend_reg    <= pend_next;
         o_ap_start  <= go;
         o_illegal   <= |bad;
      end
   end
endmodule : dram_pre_device

/* File: tb/dram_pre_asserts.sv */
// Purpose: link timing checks between the controller and memory ends
// Assumes: clock enable held high, one auto-precharge in flight at a time
// Notes:   ages count cycles since the last plain read, plain write, activate or precharge to each bank
`timescale 1ns/1ps
module dram_pre_asserts
   import dram_pre_pkg::*;
(
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst,
   input  wire logic             i_bl32,
   input  wire cmd_t             cmd,
   input  wire logic [BA_W-1:0]  bank,
   input  wire logic             ca5,
   input  wire logic [NBANK-1:0] o_bank_open,
   input  wire logic [NBANK-1:0] o_ap_start,
   input  wire logic             o_illegal
);
   logic [7:0] age_rd  [NBANK];
   logic [7:0] age_wr  [NBANK];
   logic [7:0] age_act [NBANK];
   logic [7:0] age_pre [NBANK];
   wire logic             all_pre = cmd == CMD_PRE && ca5;
   wire logic [NBANK-1:0] sel     = all_pre ? '1 : NBANK'(1) << bank;
   wire logic             is_wr   = cmd == CMD_WR || cmd == CMD_MWR;
   wire logic [NBANK-1:0] hit_rd  = (cmd == CMD_RD && !ca5) ? sel : '0;
   wire logic [NBANK-1:0] hit_wr  = (is_wr && !ca5) ? sel : '0;
   wire logic [NBANK-1:0] hit_act = (cmd == CMD_ACT) ? sel : '0;
   wire logic [NBANK-1:0] hit_pre = (cmd == CMD_PRE) ? sel : '0;
   wire logic [TW-1:0]    rd_min  = i_bl32 ? RD_PRE32 : RD_PRE16;
   wire logic [TW-1:0]    wr_min  = i_bl32 ? WR_PRE32 : WR_PRE16;

   // saturating age, restarts at one in the cycle after a hit
   function automatic logic [7:0] bump(input logic [7:0] a, input logic h);
      return h ? 8'h01 : ((a == 8'hff) ? a : a + 8'h01);
   endfunction : bump

   always_ff @(posedge i_ref_clk) begin
      for (int b = 0; b < NBANK; b++) begin
         age_rd[b]  <= i_rst ? 8'hff : bump(age_rd[b], hit_rd[b]);
         age_wr[b]  <= i_rst ? 8'hff : bump(age_wr[b], hit_wr[b]);
         age_act[b] <= i_rst ? 8'hff : bump(age_act[b], hit_act[b]);
         age_pre[b] <= i_rst ? 8'hff : bump(age_pre[b], hit_pre[b]);
      end
   end

   default clocking dck @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   a_rd_pre_gap: assert property (
      cmd == CMD_PRE && !ca5 |-> age_rd[bank] >= rd_min)
      else $error("read to precharge too close");
   a_wr_pre_gap: assert property (
      cmd == CMD_PRE && !ca5 |-> age_wr[bank] >= wr_min)
      else $error("write to precharge too close");
   a_ras_pre: assert property (
      cmd == CMD_PRE && !ca5 && o_bank_open[bank] |-> age_act[bank] >= N_RAS)
      else $error("precharge before row active time");
   a_rp_act: assert property (
      cmd == CMD_ACT |-> age_pre[bank] >= N_RPPB)
      else $error("activate before precharge time");
   a_rc_act: assert property (
      cmd == CMD_ACT |-> age_act[bank] >= N_RC)
      else $error("activate before row cycle time");
   a_rcd_access: assert property (
      cmd == CMD_RD || is_wr |-> age_act[bank] >= N_RCD)
      else $error("access before activate delay");
   a_pre_all: assert property (
      all_pre |=> o_bank_open == '0)
      else $error("banks open after precharge all");
   a_open_keep: assert property (
      (cmd == CMD_RD || is_wr) && !ca5 |=> o_bank_open[$past(bank)])
      else $error("bank closed by plain access");
   a_rdap_start: assert property (
      cmd == CMD_RD && ca5 && !i_bl32 |-> ##[1:5] (o_ap_start != '0))
      else $error("read auto precharge missing");
   a_wrap_start: assert property (
      is_wr && ca5 && !i_bl32 |-> (o_ap_start == '0)[*8] ##[8:12]
      (o_ap_start != '0))
      else $error("write auto precharge mistimed");
   a_no_illegal: assert property (
      cmd != CMD_NOP |=> !o_illegal)
      else $error("device saw a bad command");
endmodule : dram_pre_asserts

/* File: tb/dram_precharge_timing_test.sv */
// Purpose: drives controller requests and checks link spacing
// Assumes: clock enable tied high, banks chosen at random
// Notes:   expected gaps are link cycles between taken requests
`timescale 1ns/1ps
module dram_precharge_timing_test
   import dram_pre_pkg::*;
;
   logic             i_ref_clk, i_rst, i_bl32, i_req_valid, i_req_flag;
   cmd_t             i_req_cmd;
   logic [BA_W-1:0]  i_req_bank;
   logic             o_req_taken, illegal;
   logic [NBANK-1:0] ctl_open, dev_open, ap_start, mopen;
   int               cyc, fail_count, n_checks, t0, t1, t2, hb;
   int               rd_gap, wr_gap;
   int               ap_seen = 0;

   dram_cmd_if link_bus();
   dram_pre_ctrl dram_pre_ctrl_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
      .i_ce(1'b1), .i_bl32(i_bl32), .i_req_valid(i_req_valid),
      .i_req_cmd(i_req_cmd), .i_req_bank(i_req_bank),
      .i_req_flag(i_req_flag), .link(link_bus),
      .o_req_taken(o_req_taken), .o_bank_open(ctl_open));
   dram_pre_device dram_pre_device_inst (.i_ref_clk(i_ref_clk),
      .i_rst(i_rst), .i_ce(1'b1), .i_bl32(i_bl32), .link(link_bus),
      .o_bank_open(dev_open), .o_ap_start(ap_start), .o_illegal(illegal));
   dram_pre_asserts dram_pre_asserts_inst (.i_ref_clk(i_ref_clk),
      .i_rst(i_rst), .i_bl32(i_bl32), .cmd(link_bus.cmd),
      .bank(link_bus.bank), .ca5(link_bus.ca5), .o_bank_open(dev_open),
      .o_ap_start(ap_start), .o_illegal(illegal));

   initial begin
      i_ref_clk = 1'b0;
      forever #10 i_ref_clk = ~i_ref_clk;
   end

   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (ap_start != '0) ap_seen <= ap_seen + 1;
      if (cyc == 6000) begin
         fail_count++;
         final_report();
      end
   end

   function automatic int mx(input int a, input int b);
      return (a > b) ? a : b;
   endfunction : mx

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %0d want %0d", $time, seen, exp);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   task automatic put(input cmd_t c, input int b, input logic f);
      @(posedge i_ref_clk);
      i_req_valid <= 1'b1;
      i_req_cmd   <= c;
      i_req_bank  <= BA_W'(b);
      i_req_flag  <= f;
   endtask : put

   // holds the request until taken, then updates the open-bank model
   task automatic send(input cmd_t c, input int b, input logic f,
                       output int t);
      int n;
      put(c, b, f);
      n = 0;
      do begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end while (o_req_taken !== 1'b1 && n < 80);
      check(n < 80, 1);
      t = cyc;
      if (c == CMD_ACT) mopen[b] = 1'b1;
      else if (c == CMD_PRE && f) mopen = '0;
      else if (c == CMD_PRE || f) mopen[b] = 1'b0;
      check(ctl_open, mopen);
   endtask : send

   task automatic quiet();
      @(posedge i_ref_clk);
      i_req_valid <= 1'b0;
   endtask : quiet

   task automatic do_reset(input logic bl);
      @(posedge i_ref_clk);
      i_rst       <= 1'b1;
      i_bl32      <= bl;
      i_req_valid <= 1'b0;
      repeat (4) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      mopen = '0;
      hb = bl ? HALF_BL32 : HALF_BL16;
      rd_gap = mx(mx(hb, hb - RTP_OFS + C_RTP), 2);
      wr_gap = WL_CYC + hb + WR_EXTRA + C_WR;
   endtask : do_reset

   task automatic plain(input cmd_t c);
      int b;
      b = $urandom % NBANK;
      send(CMD_ACT, b, 1'b0, t0);
      send(c, b, 1'b0, t1);
      check(t1 - t0, 2);
      send(CMD_PRE, b, 1'b0, t2);
      check(t2 - t1, (c == CMD_RD) ? rd_gap : wr_gap);
      $display("test plain %s bank %0d done", c.name(), b);
   endtask : plain

   // access with auto-precharge; probe tries a read to the closed bank
   task automatic apcase(input cmd_t c, input bit probe);
      int b, a0, k, st;
      b = $urandom % NBANK;
      a0 = ap_seen;
      send(CMD_ACT, b, 1'b0, t0);
      send(c, b, 1'b1, t1);
      st = (c == CMD_RD) ? mx(hb - RTP_OFS + C_RTP, C_RAS - 2) : wr_gap;
      if (probe) begin
         put(CMD_RD, b, 1'b0);
         k = 0;
         repeat (20) begin
            @(posedge i_ref_clk);
            #1;
            if (o_req_taken === 1'b1) k++;
         end
         check(k, 0);
         check(ap_seen - a0, 1);
         check(dev_open[b], 1'b0);
      end
      send(CMD_ACT, b, 1'b0, t2);
      if (!probe) check(t2 - t1, mx(mx(st + C_RPPB, C_RC - 2), 2));
      send(CMD_PRE, b, 1'b0, t0);
      check(t0 - t2, mx(C_RAS, 2));
      $display("test auto %s bank %0d done", c.name(), b);
   endtask : apcase

   // write then read with auto-precharge waits out write recovery
   task automatic wr_rdap();
      int b;
      b = $urandom % NBANK;
      send(CMD_ACT, b, 1'b0, t0);
      send(CMD_WR, b, 1'b0, t1);
      send(CMD_RD, b, 1'b1, t2);
      check(t2 - t1, mx(wr_gap - (hb - RTP_OFS + C_RTP), 2));
      $display("test write then read auto bank %0d done", b);
   endtask : wr_rdap

   task automatic allpre();
      int b;
      b = $urandom % NBANK;
      send(CMD_ACT, b, 1'b0, t0);
      send(CMD_ACT, b ^ 1, 1'b0, t1);
      send(CMD_PRE, b, 1'b1, t2);
      quiet();
      #1;
      check(dev_open, '0);
      send(CMD_ACT, b, 1'b0, t0);
      quiet();
      $display("test precharge all bank %0d done", b);
   endtask : allpre

   initial begin
      i_rst = 1'b1;
      i_bl32 = 1'b0;
      i_req_valid = 1'b0;
      i_req_cmd = CMD_NOP;
      i_req_bank = '0;
      i_req_flag = 1'b0;
      cyc = 0;
      fail_count = 0;
      n_checks = 0;
      void'($urandom(15));
      for (int m = 0; m < 2; m++) begin
         do_reset(m[0]);
         plain(CMD_RD);
         plain(CMD_WR);
         plain(CMD_MWR);
         apcase(CMD_RD, 1'b0);
         apcase(CMD_WR, 1'b0);
         apcase(CMD_MWR, 1'b0);
         apcase(CMD_RD, 1'b1);
         wr_rdap();
         allpre();
      end
      final_report();
   end
endmodule : dram_precharge_timing_test
